// file: ics_map.svh
/*
 file holds the timing counts, widths and reset values of the instruction cycle sequencer.
 assumes it is included once per compile unit by bare name.
*/
`ifndef ICS_MAP_SVH
`define ICS_MAP_SVH
`define ICS_PHASES       4
`define ICS_PHASE_LAST   2'h3
`define ICS_PC_RESET     12'h000
`define ICS_ACCUM_RESET  8'h00
`define ICS_PC_LOW_ADDR  8'h02
`define ICS_STACK_DEPTH  8
`endif

// file: ics_pkg.sv
/*
 file holds the types of the instruction cycle sequencer.
 assumes no other package is needed.
*/
package ics_pkg;
    typedef enum logic [4:0] {
        ICS_NOP       = 5'h00,
        ICS_MOV_M2A   = 5'h01,
        ICS_MOV_A2M   = 5'h02,
        ICS_MOV_I2A   = 5'h03,
        ICS_ADD       = 5'h04,
        ICS_SUB       = 5'h05,
        ICS_AND       = 5'h06,
        ICS_OR        = 5'h07,
        ICS_XOR       = 5'h08,
        ICS_INVERT    = 5'h09,
        ICS_INC       = 5'h0a,
        ICS_DEC       = 5'h0b,
        ICS_ROT_RIGHT = 5'h0c,
        ICS_ROT_LEFT  = 5'h0d,
        ICS_BSET      = 5'h0e,
        ICS_BCLR      = 5'h0f,
        ICS_JUMP      = 5'h10,
        ICS_CALL      = 5'h11,
        ICS_RETURN    = 5'h12,
        ICS_INT_EXIT  = 5'h13,
        ICS_TABLE     = 5'h14,
        ICS_SKIP_Z    = 5'h15,
        ICS_SKIP_NZ   = 5'h16,
        ICS_SKIP_BZ   = 5'h17,
        ICS_SKIP_BNZ  = 5'h18
    } ics_op_type;

    typedef enum logic [1:0] {
        ICS_PH_FETCH  = 2'b00,
        ICS_PH_READ   = 2'b01,
        ICS_PH_EXEC   = 2'b11,
        ICS_PH_WRITE  = 2'b10
    } ics_phase_type;

    // decoded instruction word as it comes from program memory
    typedef struct packed {
        ics_op_type  op;
        logic        to_mem;
        logic [2:0]  bit_sel;
        logic [7:0]  operand;
        logic [11:0] target;
    } ics_instr_type;

    typedef struct packed {
        logic zero;
        logic carry;
    } ics_flags_type;
endpackage

// file: ics_core.sv
/*
 file holds the instruction cycle sequencer core: phase counter, fetch, execute, flags.
 assumes single-cycle-read program and data memories on clk, decoded instruction words,
 data memory address 8'h02 mapped onto the program counter low byte.
*/
// Notes on behaviour
// RL1: every instruction cycle is exactly four clock periods and timing counts in these cycles.
// RL2: most instructions take one cycle; jump, call, return, interrupt return and table read two.
// RL3: a write to the program counter low byte branches there and costs one extra cycle.
// RL4: a skip takes one cycle when not taken and one more when taken.
// RL5: a taken skip bypasses exactly the next instruction, else the next one runs.
// RL6: return resumes right after the call, and a jump saves no return address.
// RL7: and, or, xor and complement set zero when the result is zero.
// RL8: add sets carry above 255 and subtract sets carry as borrow below 0.
// RL9: increment and decrement change the destination by exactly one.
// RL10: rotate through carry shifts one place, bit out to carry, carry in at the other end.
// RL11: bit set and clear change one bit and keep the rest by internal read-modify-write.
// RL12: moves go memory to accumulator, accumulator to memory and immediate to accumulator.
// RL13: the extra cycle discards the prefetched instruction and fetches at the new address.
`timescale 1ns/100ps
`include "ics_map.svh"
module ics_core
    import ics_pkg::*;
#(
    parameter int PC_WIDTH = 12,
    parameter int STACK_DEPTH = `ICS_STACK_DEPTH,
    parameter logic [7:0] LOW_BYTE_ADDR = `ICS_PC_LOW_ADDR
) (
    input  wire logic                clk,
    input  wire logic                reset_n,
    output logic [PC_WIDTH-1:0]      prog_addr,
    input  wire ics_instr_type       prog_instr,
    output logic [7:0]               data_addr,
    input  wire logic [7:0]          data_rdata,
    output logic [7:0]               data_wdata,
    output logic                     data_we,
    output logic [7:0]               accumulator_register,
    output ics_flags_type            flags,
    output logic                     cycle_start,
    output logic                     flush_cycle
);
    // ==========================================================
    // state
    ics_phase_type          phase;
    ics_instr_type          ir;
    logic                   ir_valid;
    logic [PC_WIDTH-1:0]    pc;
    logic [PC_WIDTH-1:0]    stack [STACK_DEPTH];
    logic [$clog2(STACK_DEPTH)-1:0] sp;
    logic [7:0]             opd;

    // ==========================================================
    // phase sequencing
    // RL1: four phases per cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase <= ICS_PH_FETCH;
        end else begin
            unique case (phase)
                ICS_PH_FETCH: phase <= ICS_PH_READ;
                ICS_PH_READ:  phase <= ICS_PH_EXEC;
                ICS_PH_EXEC:  phase <= ICS_PH_WRITE;
                ICS_PH_WRITE: phase <= ICS_PH_FETCH;
            endcase
        end
    end
    wire   end_cycle = (phase == ICS_PH_WRITE);
    assign cycle_start = (phase == ICS_PH_FETCH);

    // ==========================================================
    // execute
    wire   [7:0] src = opd;
    wire   [8:0] sum  = {1'b0, accumulator_register} + {1'b0, src};
    wire   [8:0] diff = {1'b0, accumulator_register} - {1'b0, src};
    wire   [7:0] bmask = 8'h01 << ir.bit_sel;
    wire   bit_val = |(src & bmask);
    logic  [7:0] res;
    logic        new_c;
    logic        z_upd;
    logic        c_upd;
    logic        writes;
    always_comb begin
        res = src;
        new_c = flags.carry;
        z_upd = 1'b0;
        c_upd = 1'b0;
        writes = 1'b0;
        unique case (ir.op)
            // RL12: three move forms
            ICS_MOV_M2A: res = src;
            ICS_MOV_I2A: res = ir.operand;
            ICS_MOV_A2M: begin
                res = accumulator_register;
                writes = 1'b1;
            end
            // RL8: carry and borrow
            ICS_ADD: begin
                res = sum[7:0];
                new_c = sum[8];
                z_upd = 1'b1;
                c_upd = 1'b1;
            end
            ICS_SUB: begin
                res = diff[7:0];
                new_c = diff[8];
                z_upd = 1'b1;
                c_upd = 1'b1;
            end
            // RL7: logic sets zero
            ICS_AND: begin
                res = accumulator_register & src;
                z_upd = 1'b1;
            end
            ICS_OR: begin
                res = accumulator_register | src;
                z_upd = 1'b1;
            end
            ICS_XOR: begin
                res = accumulator_register ^ src;
                z_upd = 1'b1;
            end
            ICS_INVERT: begin
                res = ~src;
                z_upd = 1'b1;
            end
            // RL9: step by one
            ICS_INC: begin
                res = src + 8'h01;
                z_upd = 1'b1;
            end
            ICS_DEC: begin
                res = src - 8'h01;
                z_upd = 1'b1;
            end
            // RL10: rotate through carry
            ICS_ROT_RIGHT: begin
                res = {flags.carry, src[7:1]};
                new_c = src[0];
                c_upd = 1'b1;
            end
            ICS_ROT_LEFT: begin
                res = {src[6:0], flags.carry};
                new_c = src[7];
                c_upd = 1'b1;
            end
            // RL11: single bit read-modify-write
            ICS_BSET: begin
                res = src | bmask;
                writes = 1'b1;
            end
            ICS_BCLR: begin
                res = src & ~bmask;
                writes = 1'b1;
            end
            default: res = src;
        endcase
        if (ir.to_mem && ir.op inside {ICS_ADD, ICS_SUB, ICS_AND, ICS_OR, ICS_XOR,
                                       ICS_INVERT, ICS_INC, ICS_DEC, ICS_ROT_RIGHT,
                                       ICS_ROT_LEFT})
            writes = 1'b1;
    end

    wire   live      = ir_valid && !flush_cycle;
    wire   do_write  = live && writes;
    wire   acc_load  = live && !writes && ir.op inside {ICS_MOV_M2A, ICS_MOV_I2A, ICS_ADD,
                       ICS_SUB, ICS_AND, ICS_OR, ICS_XOR, ICS_INVERT, ICS_INC, ICS_DEC,
                       ICS_ROT_RIGHT, ICS_ROT_LEFT};
    // RL3: write to the low byte is a branch
    wire   low_byte_write = do_write && (ir.operand == LOW_BYTE_ADDR);
    // RL4: skip decision
    wire   skip_taken = live && (((ir.op == ICS_SKIP_Z)   && (src == 8'h00)) ||
                                 ((ir.op == ICS_SKIP_NZ)  && (src != 8'h00)) ||
                                 ((ir.op == ICS_SKIP_BZ)  && !bit_val) ||
                                 ((ir.op == ICS_SKIP_BNZ) && bit_val));
    // RL2: two-cycle group
    wire   two_cycle = live && ir.op inside {ICS_JUMP, ICS_CALL, ICS_RETURN, ICS_INT_EXIT,
                                             ICS_TABLE};
    wire   redirect  = two_cycle || low_byte_write || skip_taken;
    wire   [PC_WIDTH-1:0] pc_low = {pc[PC_WIDTH-1:8], res};
    logic  [PC_WIDTH-1:0] next_pc;
    // RL5: skip steps over the prefetched word by flushing it; pc already points at it and advances by one
    always_comb begin
        next_pc = pc + PC_WIDTH'(1);
        if (live && ir.op inside {ICS_JUMP, ICS_CALL})
            next_pc = ir.target;
        else if (live && ir.op inside {ICS_RETURN, ICS_INT_EXIT})
            next_pc = stack[sp - 1'b1];
        else if (low_byte_write)
            next_pc = pc_low;
        // RL2: table read refetches the displaced word instead of losing it
        else if (live && ir.op == ICS_TABLE)
            next_pc = pc;
    end

    assign prog_addr  = pc;
    assign data_we    = do_write && end_cycle;

    // address follows the word being latched; write data settles at the end of execute
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            data_addr  <= 8'h00;
            data_wdata <= 8'h00;
        end else begin
            if (end_cycle)
                data_addr <= (prog_instr.op == ICS_MOV_I2A) ? 8'h00 : prog_instr.operand;
            if (phase == ICS_PH_EXEC)
                data_wdata <= res;
        end
    end

    // ==========================================================
    // registers updated once per instruction cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            opd <= 8'h00;
        end else if (phase == ICS_PH_READ) begin
            opd <= data_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pc <= `ICS_PC_RESET;
            ir <= '0;
            ir_valid <= 1'b0;
            flush_cycle <= 1'b0;
            sp <= '0;
            accumulator_register <= `ICS_ACCUM_RESET;
            flags <= '0;
        end else if (end_cycle) begin
            // RL13: prefetched word dropped on redirect
            ir <= prog_instr;
            ir_valid <= 1'b1;
            flush_cycle <= redirect;
            pc <= next_pc;
            if (acc_load)
                accumulator_register <= res;
            if (z_upd && live)
                flags.zero <= (res == 8'h00);
            if (c_upd && live)
                flags.carry <= new_c;
            // RL6: only a call pushes, return pops
            if (live && ir.op == ICS_CALL) begin
                stack[sp] <= pc;
                sp <= sp + 1'b1;
            end else if (live && ir.op inside {ICS_RETURN, ICS_INT_EXIT}) begin
                sp <= sp - 1'b1;
            end
        end
    end

    // ==========================================================
    // checks
    // RL1: cycle start every four clocks
    a_cycle_period: assert property (@(posedge clk) disable iff (!reset_n) // RL1
        cycle_start |=> !cycle_start [*3] ##1 cycle_start) else $error("cycle not 4 clocks");
    // RL2: jump flushes next cycle
    a_jump_flush: assert property (@(posedge clk) disable iff (!reset_n) // RL2
        (end_cycle && live && ir.op == ICS_JUMP) |=> flush_cycle [*4])
        else $error("jump did not cost a cycle");
    // RL3: low byte write branches
    a_low_branch: assert property (@(posedge clk) disable iff (!reset_n) // RL3
        (end_cycle && low_byte_write) |=> (flush_cycle && pc[7:0] == $past(res)))
        else $error("low byte write no branch");
    // RL4: untaken skip costs nothing extra
    a_skip_cost: assert property (@(posedge clk) disable iff (!reset_n) // RL4
        (end_cycle && live && !skip_taken && ir.op inside {[ICS_SKIP_Z:ICS_SKIP_BNZ]})
        |=> !flush_cycle) else $error("untaken skip flushed");
    // RL5: taken skip bypasses one word
    a_skip_next: assert property (@(posedge clk) disable iff (!reset_n) // RL5
        (end_cycle && skip_taken) |=> (pc == $past(pc) + PC_WIDTH'(1)) && flush_cycle)
        else $error("skip wrong target");
    // RL6: jump keeps stack depth
    a_jump_nostack: assert property (@(posedge clk) disable iff (!reset_n) // RL6
        (end_cycle && live && ir.op == ICS_JUMP) |=> sp == $past(sp))
        else $error("jump touched stack");
    // RL7: zero flag on and
    a_zero_logic: assert property (@(posedge clk) disable iff (!reset_n) // RL7
        (end_cycle && live && ir.op == ICS_AND) |=> flags.zero == ($past(res) == 8'h00))
        else $error("zero flag wrong");
    // RL8: add carry
    a_add_carry: assert property (@(posedge clk) disable iff (!reset_n) // RL8
        (end_cycle && live && ir.op == ICS_ADD) |=> flags.carry == $past(sum[8]))
        else $error("add carry wrong");
    // RL9: increment by one
    a_inc_step: assert property (@(posedge clk) disable iff (!reset_n) // RL9
        (end_cycle && live && ir.op == ICS_INC && !ir.to_mem)
        |=> accumulator_register == $past(src) + 8'h01) else $error("increment wrong");
    // RL10: rotate right carry out
    a_rot_carry: assert property (@(posedge clk) disable iff (!reset_n) // RL10
        (end_cycle && live && ir.op == ICS_ROT_RIGHT) |=> flags.carry == $past(src[0]))
        else $error("rotate carry wrong");
    // RL11: other bits kept
    a_bit_keep: assert property (@(posedge clk) disable iff (!reset_n) // RL11
        (data_we && ir.op == ICS_BSET) |-> (data_wdata & ~bmask) == (src & ~bmask)
        && (data_wdata & bmask) == bmask) else $error("bit op disturbed others");
endmodule

// file: instruction_cycle_sequencer_tb_top.sv
/*
 testbench of the instruction cycle sequencer: small programs run from a program memory model,
 the state seen at each cycle start is logged and compared with hand-worked expectations.
 assumes ics_pkg and ics_core are compiled first; memories answer combinationally.
*/
`timescale 1ns/100ps
`define chk(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module instruction_cycle_sequencer_tb_top
    import ics_pkg::*;
;
    logic              clk;
    logic              reset_n;
    logic [11:0]       prog_addr;
    ics_instr_type     prog_instr;
    logic [7:0]        data_addr;
    logic [7:0]        data_rdata;
    logic [7:0]        data_wdata;
    logic              data_we;
    logic [7:0]        accumulator_register;
    ics_flags_type     flags;
    logic              cycle_start;
    logic              flush_cycle;
    ics_instr_type     prog [0:63];
    logic [7:0]        dmem [0:255];
    logic [7:0]        la   [0:63];
    logic [1:0]        lf   [0:63];
    logic              lfl  [0:63];
    int                err_total;
    int                num_checks;

    ics_core u_ics_core (.clk(clk), .reset_n(reset_n), .prog_addr(prog_addr),
        .prog_instr(prog_instr), .data_addr(data_addr), .data_rdata(data_rdata),
        .data_wdata(data_wdata), .data_we(data_we),
        .accumulator_register(accumulator_register), .flags(flags),
        .cycle_start(cycle_start), .flush_cycle(flush_cycle));

    // ==========================================================
    // clock and memory models
    always #5 clk = ~clk;
    assign prog_instr = prog[prog_addr[5:0]];
    assign data_rdata = dmem[data_addr];
    always @(posedge clk) begin
        if (data_we === 1'b1) begin
            dmem[data_addr] <= data_wdata;
        end
    end

    function automatic ics_instr_type mk(ics_op_type op, logic tm, logic [2:0] b,
                                         logic [7:0] o, logic [11:0] t);
        mk = '{op, tm, b, o, t};
    endfunction

    task automatic clear();
        for (int i = 0; i < 64; i++) prog[i] = mk(ICS_NOP, 1'b0, 3'h0, 8'h00, 12'h000);
        for (int i = 0; i < 256; i++) dmem[i] = 8'h00;
    endtask

    // ==========================================================
    // reset, then log state at every cycle start for n cycles
    task automatic run(input int n);
        @(posedge clk);
        #1 reset_n = 1'b0;
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        for (int k = 0; k < 4 * n; k++) begin
            if (k > 0) begin
                @(posedge clk);
                #1;
            end
            `chk(cycle_start, (k % 4 == 0))
            if (data_we === 1'b1) `chk(k % 4, 3)
            if (k % 4 == 0) begin
                la[k / 4] = accumulator_register;
                lf[k / 4] = flags;
                lfl[k / 4] = flush_cycle;
            end
        end
    endtask

    // ==========================================================
    // straight-line data operations: results and flags per instruction
    task automatic alu_ops();
        logic [7:0] ea [0:17];
        logic [1:0] ef [0:17];
        ea = '{8'hf0, 8'h10, 8'hf0, 8'h00, 8'h3c, 8'h00, 8'hc3, 8'h42, 8'h00,
               8'h81, 8'h00, 8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h00, 8'h00};
        ef = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h1, 2'h3, 2'h1, 2'h1, 2'h3,
               2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h3, 2'h2};
        clear();
        prog[0] = mk(ICS_MOV_I2A, 1'b0, 3'h0, 8'hf0, 12'h0);
        prog[1] = mk(ICS_ADD, 1'b0, 3'h0, 8'h10, 12'h0);
        prog[2] = mk(ICS_SUB, 1'b0, 3'h0, 8'h11, 12'h0);
        prog[3] = mk(ICS_AND, 1'b0, 3'h0, 8'h12, 12'h0);
        prog[4] = mk(ICS_OR, 1'b0, 3'h0, 8'h13, 12'h0);
        prog[5] = mk(ICS_XOR, 1'b0, 3'h0, 8'h13, 12'h0);
        prog[6] = mk(ICS_INVERT, 1'b0, 3'h0, 8'h13, 12'h0);
        prog[7] = mk(ICS_INC, 1'b0, 3'h0, 8'h14, 12'h0);
        prog[8] = mk(ICS_DEC, 1'b0, 3'h0, 8'h15, 12'h0);
        prog[9] = mk(ICS_ROT_RIGHT, 1'b0, 3'h0, 8'h16, 12'h0);
        prog[10] = mk(ICS_ROT_LEFT, 1'b0, 3'h0, 8'h17, 12'h0);
        prog[11] = mk(ICS_MOV_M2A, 1'b0, 3'h0, 8'h18, 12'h0);
        prog[12] = mk(ICS_MOV_A2M, 1'b1, 3'h0, 8'h19, 12'h0);
        prog[13] = mk(ICS_BSET, 1'b1, 3'h5, 8'h1a, 12'h0);
        prog[14] = mk(ICS_BCLR, 1'b1, 3'h0, 8'h1b, 12'h0);
        prog[15] = mk(ICS_DEC, 1'b1, 3'h0, 8'h1c, 12'h0);
        prog[16] = mk(ICS_ADD, 1'b0, 3'h0, 8'h1e, 12'h0);
        prog[17] = mk(ICS_SUB, 1'b0, 3'h0, 8'h1f, 12'h0);
        dmem[8'h10] = 8'h20; dmem[8'h11] = 8'h20; dmem[8'h12] = 8'h0f;
        dmem[8'h13] = 8'h3c; dmem[8'h14] = 8'h41; dmem[8'h15] = 8'h01;
        dmem[8'h16] = 8'h02; dmem[8'h17] = 8'h80; dmem[8'h18] = 8'h5a;
        dmem[8'h1b] = 8'hff; dmem[8'h1e] = 8'ha6;
        run(21);
        for (int k = 0; k < 18; k++) begin
            `chk(la[k + 2], ea[k])
            `chk(lf[k + 2], ef[k])
            `chk(lfl[k + 2], 1'b0)
        end
        `chk(dmem[8'h19], 8'h5a)
        `chk(dmem[8'h1a], 8'h20)
        `chk(dmem[8'h1b], 8'hfe)
        `chk(dmem[8'h1c], 8'hff)
        `chk(dmem[8'h13], 8'h3c)
    endtask

    // ==========================================================
    // jump, call, return, table read: each costs one flushed cycle
    task automatic transfers();
        clear();
        prog[0] = mk(ICS_JUMP, 1'b0, 3'h0, 8'h00, 12'h004);
        prog[1] = mk(ICS_MOV_I2A, 1'b0, 3'h0, 8'h11, 12'h0);
        prog[4] = mk(ICS_MOV_I2A, 1'b0, 3'h0, 8'h22, 12'h0);
        prog[5] = mk(ICS_CALL, 1'b0, 3'h0, 8'h00, 12'h00a);
        prog[6] = mk(ICS_CALL, 1'b0, 3'h0, 8'h00, 12'h00b);
        prog[7] = mk(ICS_TABLE, 1'b0, 3'h0, 8'h00, 12'h0);
        prog[8] = mk(ICS_MOV_I2A, 1'b0, 3'h0, 8'h33, 12'h0);
        prog[9] = mk(ICS_JUMP, 1'b0, 3'h0, 8'h00, 12'h009);
        prog[10] = mk(ICS_RETURN, 1'b0, 3'h0, 8'h00, 12'h0);
        prog[11] = mk(ICS_INT_EXIT, 1'b0, 3'h0, 8'h00, 12'h0);
        run(16);
        for (int c = 0; c < 16; c++) begin
            `chk(lfl[c], 16'h2aa4 >> c & 1'b1)
            `chk(la[c], (c < 4) ? 8'h00 : (c < 15) ? 8'h22 : 8'h33)
        end
    endtask

    // ==========================================================
    // low-byte write and the four skip forms, zero and bit-set taken, nonzero and bit-clear not taken
    task automatic skips();
        clear();
        prog[0] = mk(ICS_MOV_I2A, 1'b0, 3'h0, 8'h05, 12'h0);
        prog[1] = mk(ICS_MOV_A2M, 1'b1, 3'h0, 8'h02, 12'h0);
        prog[2] = mk(ICS_MOV_I2A, 1'b0, 3'h0, 8'hee, 12'h0);
        prog[5] = mk(ICS_SKIP_Z, 1'b0, 3'h0, 8'h20, 12'h0);
        prog[6] = mk(ICS_MOV_I2A, 1'b0, 3'h0, 8'haa, 12'h0);
        prog[7] = mk(ICS_SKIP_NZ, 1'b0, 3'h0, 8'h20, 12'h0);
        prog[8] = mk(ICS_SKIP_BZ, 1'b0, 3'h3, 8'h22, 12'h0);
        prog[9] = mk(ICS_SKIP_BNZ, 1'b0, 3'h3, 8'h22, 12'h0);
        prog[10] = mk(ICS_MOV_I2A, 1'b0, 3'h0, 8'hab, 12'h0);
        prog[11] = mk(ICS_MOV_I2A, 1'b0, 3'h0, 8'h77, 12'h0);
        prog[12] = mk(ICS_JUMP, 1'b0, 3'h0, 8'h00, 12'h00c);
        dmem[8'h22] = 8'h08;
        run(12);
        for (int c = 0; c < 12; c++) begin
            `chk(lfl[c], 12'h228 >> c & 1'b1)
            `chk(la[c], (c < 2) ? 8'h00 : (c < 11) ? 8'h05 : 8'h77)
        end
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        err_total = 0;
        num_checks = 0;
        clear();
        alu_ops();
        transfers();
        skips();
        summarize();
    end
endmodule
